// ===== design/apcea_top.sv
// Register file, sample divider, sign detection and interrupt for the energy block
`timescale 1ns/1ps
`default_nettype none
module apcea_top
    import apcea_pkg::*;
#(
    parameter int SAMPLE_DIV = apcea_pkg::SAMPLE_CYCLES
)(
    input  wire logic                            clk,
    input  wire logic                            rst_b,
    input  wire logic [2:0][apcea_pkg::REG_W-1:0] total_power,
    input  wire logic [2:0][apcea_pkg::REG_W-1:0] fund_power,
    input  wire logic [7:0]                      reg_addr,
    input  wire logic                            reg_wr,
    input  wire logic [31:0]                     reg_wdata,
    input  wire logic                            reg_rd,
    output logic [31:0]                          reg_rdata,
    output logic [2:0]                           phase_power_negative,
    output logic                                 interrupt_out_0_n
);
    import apcea_pkg::*;

    // Pulse and strobe must never fall in one cycle
    if (SAMPLE_DIV < 2) begin : g_div_check
        $error("SAMPLE_DIV must be at least 2");
    end

    // ==================== State
    apcea_regs_t                 st_r;
    apcea_regs_t                 st_nxt;
    logic [NCH-1:0]              ch_pulse;
    logic [NCH-1:0]              ch_neg;
    logic [NCH-1:0][ENRG_W-1:0]  ch_energy;
    logic [NCH-1:0][REG_W-1:0]   ch_power;
    logic [2:0]                  sel_pulse;
    logic [2:0]                  sel_neg;
    logic [31:0]                 rev_set;
    logic [31:0]                 rd_val;
    logic                        wr_status;

    assign ch_power = {fund_power, total_power};

    // ==================== Power paths, three total then three fundamental
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        apcea_channel u_ch (
            .clk            (clk),
            .rst_b          (rst_b),
            .sample_stb     (st_r.stb),
            .power_in       (ch_power[i]),
            .gain           (st_r.gain[i]),
            .offset         (st_r.offs[i]),
            .threshold      (st_r.thr),
            .pulse          (ch_pulse[i]),
            .pulse_negative (ch_neg[i]),
            .energy         (ch_energy[i])
        );
    end

    // ==================== Sign watching
    always_comb begin
        rev_set = '0;
        for (int p = 0; p < 3; p++) begin
            if (st_r.accumulation_mode_control[SIGN_SEL_BIT]) begin
                sel_pulse[p] = ch_pulse[p+3];
                sel_neg[p]   = ch_neg[p+3];
            end else begin
                sel_pulse[p] = ch_pulse[p];
                sel_neg[p]   = ch_neg[p];
            end
            if (sel_pulse[p] && (sel_neg[p] != st_r.psign[p])) begin
                rev_set[REV_A_BIT+p] = 1'b1;
            end
        end
    end

    // ==================== Register read decode
    always_comb begin
        rd_val = 32'h0000_0000;
        if (reg_addr >= OFS_GAIN_BASE && reg_addr < OFS_GAIN_BASE + 8'(NCH)) begin
            rd_val = {4'h0, apcea_sext(st_r.gain[3'(reg_addr - OFS_GAIN_BASE)])};
        end else if (reg_addr >= OFS_OFFS_BASE && reg_addr < OFS_OFFS_BASE + 8'(NCH)) begin
            rd_val = {4'h0, apcea_sext(st_r.offs[3'(reg_addr - OFS_OFFS_BASE)])};
        end else if (reg_addr >= OFS_ENRG_BASE && reg_addr < OFS_ENRG_BASE + 8'(NCH)) begin
            rd_val = ch_energy[3'(reg_addr - OFS_ENRG_BASE)];
        end else begin
            unique case (reg_addr)
                OFS_THR_HIGH: rd_val = {8'h00, st_r.thr[THR_W-1:THR_H_W]};
                OFS_THR_LOW:  rd_val = {8'h00, st_r.thr[THR_H_W-1:0]};
                OFS_ACCUMULATION_MODE_CONTROL:  rd_val = {24'h00_0000, st_r.accumulation_mode_control};
                OFS_EVENT_STATUS_0:  rd_val = st_r.status;
                OFS_EVENT_ENABLE_0:    rd_val = st_r.mask;
                OFS_PSIGN:    rd_val = {29'h0, st_r.psign};
                default:      rd_val = 32'h0000_0000;
            endcase
        end
    end

    assign wr_status = reg_wr && (reg_addr == OFS_EVENT_STATUS_0);

    // ==================== Next state
    always_comb begin
        st_nxt = st_r;
        if (st_r.div >= 32'(SAMPLE_DIV - 1)) begin
            st_nxt.div = 32'h0;
            st_nxt.stb = 1'b1;
        end else begin
            st_nxt.div = st_r.div + 32'h1;
            st_nxt.stb = 1'b0;
        end
        if (reg_rd) begin
            st_nxt.rdata = rd_val;
        end
        if (reg_wr) begin
            if (reg_addr >= OFS_GAIN_BASE && reg_addr < OFS_GAIN_BASE + 8'(NCH)) begin
                st_nxt.gain[3'(reg_addr - OFS_GAIN_BASE)] = reg_wdata[REG_W-1:0];
            end
            if (reg_addr >= OFS_OFFS_BASE && reg_addr < OFS_OFFS_BASE + 8'(NCH)) begin
                st_nxt.offs[3'(reg_addr - OFS_OFFS_BASE)] = reg_wdata[REG_W-1:0];
            end
            if (reg_addr == OFS_THR_HIGH) begin
                st_nxt.thr[THR_W-1:THR_H_W] = reg_wdata[THR_H_W-1:0];
            end
            if (reg_addr == OFS_THR_LOW) begin
                st_nxt.thr[THR_H_W-1:0] = reg_wdata[THR_H_W-1:0];
            end
            if (reg_addr == OFS_ACCUMULATION_MODE_CONTROL) begin
                st_nxt.accumulation_mode_control = reg_wdata[7:0];
            end
            if (reg_addr == OFS_EVENT_ENABLE_0) begin
                st_nxt.mask = reg_wdata;
            end
        end
        if (wr_status) begin
            st_nxt.status = st_r.status & ~reg_wdata;
        end
        st_nxt.status = (st_nxt.status | rev_set) & REV_MASK;
        for (int p = 0; p < 3; p++) begin
            if (rev_set[REV_A_BIT+p]) begin
                st_nxt.psign[p] = sel_neg[p];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r         <= '0;
            st_r.gain    <= {NCH{GAIN_RST}};
            st_r.offs    <= {NCH{OFFS_RST}};
            st_r.thr     <= THR_RST;
            st_r.accumulation_mode_control <= ACCUMULATION_MODE_CONTROL_RST;
            st_r.mask    <= MASK_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==================== Outputs
    assign reg_rdata            = st_r.rdata;
    assign phase_power_negative = st_r.psign;
    assign interrupt_out_0_n    = !(|(st_r.status & st_r.mask & REV_MASK));

    // ==================== Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic [31:0] stb_gap;
    always_ff @(posedge clk) begin
        if (!rst_b || st_nxt.stb) begin
            stb_gap <= 32'h0;
        end else begin
            stb_gap <= stb_gap + 32'h1;
        end
    end

    sample_period_a: assert property (
        st_r.stb |-> $past(stb_gap) == 32'(SAMPLE_DIV - 1))
        else $error("sample strobe period wrong");
    stb_gap_a: assert property (stb_gap < 32'(SAMPLE_DIV))
        else $error("sample strobe missing");
    rev_sets_a: assert property (
        sel_pulse[0] && sel_neg[0] != st_r.psign[0]
        |=> st_r.status[REV_A_BIT] && st_r.psign[0] == $past(sel_neg[0]))
        else $error("phase A reversal not flagged");
    sign_together_a: assert property (
        $changed(st_r.psign) |-> $past(rev_set[8:6]) != 3'b000)
        else $error("sign bit changed without reversal flag");
    no_false_rev_a: assert property (
        !(|sel_pulse) && !wr_status |=> $stable(st_r.status))
        else $error("status changed with no event");
    irq_low_a: assert property (
        st_r.status[REV_A_BIT+1] && st_r.mask[REV_A_BIT+1] |-> !interrupt_out_0_n)
        else $error("enabled phase B reversal did not drive interrupt");
    w1c_clear_a: assert property (
        wr_status && reg_wdata[REV_A_BIT] && !rev_set[REV_A_BIT]
        |=> !st_r.status[REV_A_BIT])
        else $error("status bit not cleared by write of one");
    set_wins_a: assert property (
        wr_status && reg_wdata[REV_A_BIT+2] && rev_set[REV_A_BIT+2]
        |=> st_r.status[REV_A_BIT+2])
        else $error("reversal lost against a clear");
    thr_read_a: assert property (
        reg_wr && reg_addr == OFS_THR_HIGH ##1 !reg_wr ##1 reg_rd
        && reg_addr == OFS_THR_HIGH && !reg_wr
        |=> reg_rdata == {8'h00, $past(reg_wdata[23:0], 3)})
        else $error("threshold upper half read back wrong");
    gain_read_a: assert property (
        reg_wr && reg_addr == OFS_GAIN_BASE ##1 !reg_wr ##1 reg_rd
        && reg_addr == OFS_GAIN_BASE && !reg_wr
        |=> reg_rdata == {4'h0, {4{reg_rdata[23]}}, $past(reg_wdata[23:0], 3)})
        else $error("gain word not sign extended");
    sel_fund_a: assert property (st_r.accumulation_mode_control[SIGN_SEL_BIT] |-> sel_pulse == ch_pulse[5:3])
        else $error("sign watch not on fundamental path");

    cov_rev_c: cover property (|rev_set && st_r.mask[8:6] != 3'b000);
    cov_clear_c: cover property (!interrupt_out_0_n ##1 wr_status ##1 interrupt_out_0_n);
    cov_neg_c: cover property (ch_pulse[0] && ch_neg[0]);
    cov_fund_c: cover property (st_r.accumulation_mode_control[SIGN_SEL_BIT] && |rev_set);
endmodule
`default_nettype wire

// ===== design/apcea_pkg.sv
// Shared constants, types and helpers for the active power calibration and energy block
// Contract
// - Scale each phase power by one plus signed gain over two to the 23rd.
// - Gain 0xc00000 halves power; gain 0x400000 raises it by half.
// - Three total-path gains and three fundamental-path gains, one per phase.
// - Gains and offsets travel as 32-bit words, top nibble zero, sign-extended to 28.
// - Add a signed 24-bit offset per phase and path, one LSB per multiplier LSB.
// - Every 125 us add each calibrated power into a 56-bit signed accumulator.
// - On reaching threshold emit one pulse and take the threshold off the accumulator.
// - The accumulator sign at a threshold crossing is the phase power sign.
// - Count pulses into 32-bit accumulators; reads return their contents.
// - Accumulation is signed; negative power lowers the stored energy.
// - One signed 48-bit threshold serves all phases and both paths.
// - Threshold is two 32-bit words, upper and lower halves, top 8 bits zero.
// - Mode bit 6 picks total (0) or fundamental (1) power for sign watching.
// - Status bits 8,7,6 flag a sign change of phases C,B,A.
// - Sign bits 2,1,0 update with the flags: 0 positive, 1 negative.
// - Enabled reversal flags pull the active-low interrupt output low.
// - Software reads sign after status, then writes one to clear and release.
`default_nettype none
package apcea_pkg;

    // ==================== Timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int SAMPLE_PERIOD_NS = 125000;
    localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // ==================== Widths
    localparam int REG_W   = 24;
    localparam int DSP_W   = 28;
    localparam int ACC_W   = 56;
    localparam int THR_W   = 48;
    localparam int THR_H_W = 24;
    localparam int ENRG_W  = 32;
    localparam int GAIN_FRAC = 23;
    localparam int NCH     = 6;

    // ==================== Register offsets
    localparam logic [7:0] OFS_GAIN_BASE   = 8'h00;
    localparam logic [7:0] OFS_OFFS_BASE   = 8'h08;
    localparam logic [7:0] OFS_ENRG_BASE   = 8'h10;
    localparam logic [7:0] OFS_THR_HIGH    = 8'h18;
    localparam logic [7:0] OFS_THR_LOW     = 8'h19;
    localparam logic [7:0] OFS_ACCUMULATION_MODE_CONTROL     = 8'h1a;
    localparam logic [7:0] OFS_EVENT_STATUS_0     = 8'h1b;
    localparam logic [7:0] OFS_EVENT_ENABLE_0       = 8'h1c;
    localparam logic [7:0] OFS_PSIGN       = 8'h1d;

    // ==================== Fields
    localparam int SIGN_SEL_BIT  = 6;
    localparam int REV_A_BIT     = 6;
    localparam logic [31:0] REV_MASK = 32'h0000_01c0;

    // ==================== Reset values
    localparam logic [REG_W-1:0] GAIN_RST    = 24'h00_0000;
    localparam logic [REG_W-1:0] OFFS_RST    = 24'h00_0000;
    localparam logic [THR_W-1:0] THR_RST     = 48'h0000_0000_0000;
    localparam logic [7:0]       ACCUMULATION_MODE_CONTROL_RST = 8'h00;
    localparam logic [31:0]      MASK_RST    = 32'h0000_0000;

    typedef struct packed {
        logic [ACC_W-1:0]  acc;
        logic [ENRG_W-1:0] energy;
        logic              pulse;
        logic              negative;
    } apcea_chan_t;

    typedef struct packed {
        logic [NCH-1:0][REG_W-1:0] gain;
        logic [NCH-1:0][REG_W-1:0] offs;
        logic [THR_W-1:0]          thr;
        logic [7:0]                accumulation_mode_control;
        logic [31:0]               status;
        logic [31:0]               mask;
        logic [2:0]                psign;
        logic [31:0]               div;
        logic                      stb;
        logic [31:0]               rdata;
    } apcea_regs_t;

    function automatic logic [DSP_W-1:0] apcea_sext(input logic [REG_W-1:0] v);
        return {{(DSP_W-REG_W){v[REG_W-1]}}, v};
    endfunction

endpackage
`default_nettype wire

// ===== design/apcea_channel.sv
// One power path: calibration, first-stage threshold integrator, second-stage pulse counter
`timescale 1ns/1ps
`default_nettype none
module apcea_channel
    import apcea_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        sample_stb,
    input  wire logic [apcea_pkg::REG_W-1:0] power_in,
    input  wire logic [apcea_pkg::REG_W-1:0] gain,
    input  wire logic [apcea_pkg::REG_W-1:0] offset,
    input  wire logic [apcea_pkg::THR_W-1:0] threshold,
    output logic                             pulse,
    output logic                             pulse_negative,
    output logic [apcea_pkg::ENRG_W-1:0]     energy
);
    import apcea_pkg::*;

    apcea_chan_t              st_r;
    apcea_chan_t              st_nxt;
    logic signed [2*DSP_W-1:0] prod;
    logic signed [DSP_W-1:0]   scaled;
    logic signed [ACC_W-1:0]   acc_sum;
    logic signed [ACC_W-1:0]   thr_ext;

    always_comb begin
        prod    = $signed(apcea_sext(power_in)) * $signed(apcea_sext(gain));
        scaled  = $signed(apcea_sext(power_in)) + $signed(prod[GAIN_FRAC +: DSP_W])
                + $signed(apcea_sext(offset));
        acc_sum = $signed(st_r.acc) + ACC_W'(scaled);
        thr_ext = ACC_W'($signed(threshold));
        st_nxt  = st_r;
        st_nxt.pulse = 1'b0;
        if (st_r.pulse) begin
            if (st_r.negative) begin
                st_nxt.energy = st_r.energy - 32'h0000_0001;
            end else begin
                st_nxt.energy = st_r.energy + 32'h0000_0001;
            end
        end
        if (sample_stb) begin
            st_nxt.acc = acc_sum;
            if (acc_sum >= thr_ext) begin
                st_nxt.acc      = acc_sum - thr_ext;
                st_nxt.pulse    = 1'b1;
                st_nxt.negative = 1'b0;
            end else if (acc_sum <= -thr_ext) begin
                st_nxt.acc      = acc_sum + thr_ext;
                st_nxt.pulse    = 1'b1;
                st_nxt.negative = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pulse          = st_r.pulse;
    assign pulse_negative = st_r.negative;
    assign energy         = st_r.energy;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    count_up_a: assert property (pulse && !pulse_negative |=> energy == $past(energy) + 32'h1)
        else $error("energy did not count up on positive pulse");
    count_down_a: assert property (pulse && pulse_negative |=> energy == $past(energy) - 32'h1)
        else $error("energy did not count down on negative pulse");
    pulse_cause_a: assert property (!sample_stb |=> !pulse)
        else $error("pulse without a sample strobe");
    pulse_thr_a: assert property (
        sample_stb && !(acc_sum >= thr_ext) && !(acc_sum <= -thr_ext)
        |=> !pulse && st_r.acc == $past(acc_sum))
        else $error("accumulator not updated below threshold");
endmodule
`default_nettype wire

// ===== verification/apcea_tb.sv
// Self-checking bench for the active power calibration and energy block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import apcea_pkg::*;

    // ====================
    // Clock, reset and ports
    localparam int DIV = 100;
    logic                   clk;
    logic                   rst_b;
    logic [2:0][REG_W-1:0]  total_power;
    logic [2:0][REG_W-1:0]  fund_power;
    logic [7:0]             reg_addr;
    logic                   reg_wr;
    logic [31:0]            reg_wdata;
    logic                   reg_rd;
    logic [31:0]            reg_rdata;
    logic [2:0]             phase_power_negative;
    logic                   interrupt_out_0_n;
    int                     n_errors;
    int                     n_compared;
    logic [31:0]            e_a;
    logic [31:0]            e_b;

    apcea_top #(.SAMPLE_DIV(DIV)) i_dut (
        .clk                  (clk),
        .rst_b                (rst_b),
        .total_power          (total_power),
        .fund_power           (fund_power),
        .reg_addr             (reg_addr),
        .reg_wr               (reg_wr),
        .reg_wdata            (reg_wdata),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .phase_power_negative (phase_power_negative),
        .interrupt_out_0_n    (interrupt_out_0_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ====================
    // Access tasks
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(name, v, exp);
    endtask

    task automatic samples(input int n);
        repeat (n * DIV) @(posedge clk);
    endtask

    task automatic set_power(input logic [2:0][REG_W-1:0] t, input logic [2:0][REG_W-1:0] f);
        @(posedge clk);
        total_power <= t;
        fund_power  <= f;
    endtask

    task automatic wait_irq_low();
        int i;
        for (i = 0; i < 4 * DIV && interrupt_out_0_n !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk("interrupt wait", {31'h0, interrupt_out_0_n}, 32'h0);
        if (interrupt_out_0_n !== 1'b0) begin
            final_report();
        end
    endtask

    task automatic final_report();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ====================
    // Main sequence
    initial begin
        int i;
        n_errors = 0;
        n_compared = 0;
        rst_b = 1'b0;
        total_power = '0;
        fund_power = '0;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 32'h0000_0000;
        reg_rd = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        // Every mapped register resets to zero, unmapped words read zero
        for (i = 0; i < 32; i++) rd_chk("reset read", i[7:0], 32'h0000_0000);
        wr(OFS_THR_LOW, 32'h0000_03e8);
        chk("irq after reset", {31'h0, interrupt_out_0_n}, 32'h1);
        // Register formats and refusals
        wr(8'h00, 32'hffc0_0000);
        rd_chk("gain a neg", 8'h00, 32'h0fc0_0000);
        wr(8'h01, 32'h0040_0000);
        rd_chk("gain b pos", 8'h01, 32'h0040_0000);
        wr(8'h09, 32'h0000_00fa);
        rd_chk("offset b", 8'h09, 32'h0000_00fa);
        wr(OFS_THR_HIGH, 32'hff00_0001);
        rd_chk("thr high", OFS_THR_HIGH, 32'h0000_0001);
        wr(OFS_THR_HIGH, 32'h0000_0000);
        rd_chk("thr low", OFS_THR_LOW, 32'h0000_03e8);
        wr(OFS_PSIGN, 32'h0000_0007);
        rd_chk("sign ro", OFS_PSIGN, 32'h0000_0000);
        wr(8'h1f, 32'h1234_5678);
        rd_chk("unmapped", 8'h1f, 32'h0000_0000);
        // Calibrated total powers and fundamental A each worth one threshold per sample; C total negative
        set_power({-24'sd1000, 24'sd500, 24'sd2000}, {24'sd0, 24'sd0, 24'sd1000});
        samples(20);
        set_power('0, '0);
        repeat (4) @(posedge clk);
        rd(8'h11, e_b);
        rd(8'h10, e_a);
        // Twenty strobes see the powers, each nonzero one worth exactly one threshold
        chk("energy b counts", e_b, 32'h0000_0014);
        chk("gain half", e_a, 32'h0000_0014);
        rd_chk("energy c neg", 8'h12, 32'hffff_ffec);
        rd_chk("fund a", 8'h13, 32'h0000_0014);
        rd_chk("fund b", 8'h14, 32'h0000_0000);
        rd_chk("fund c", 8'h15, 32'h0000_0000);
        chk("irq masked", {31'h0, interrupt_out_0_n}, 32'h1);
        rd_chk("status c", OFS_EVENT_STATUS_0, 32'h0000_0100);
        rd_chk("sign c", OFS_PSIGN, 32'h0000_0004);
        chk("sign pins", {29'h0, phase_power_negative}, 32'h4);
        // Enable, then clear by write-one
        wr(OFS_EVENT_ENABLE_0, REV_MASK);
        chk("irq enabled", {31'h0, interrupt_out_0_n}, 32'h0);
        wr(OFS_EVENT_STATUS_0, 32'h0000_0100);
        chk("irq released", {31'h0, interrupt_out_0_n}, 32'h1);
        rd_chk("status clr", OFS_EVENT_STATUS_0, 32'h0000_0000);
        // Fundamental path monitored: total B sign change is ignored
        wr(OFS_ACCUMULATION_MODE_CONTROL, 32'h0000_0040);
        rd_chk("mode", OFS_ACCUMULATION_MODE_CONTROL, 32'h0000_0040);
        set_power({24'sd0, -24'sd1000, 24'sd0}, {24'sd0, 24'sd0, -24'sd1000});
        wait_irq_low();
        samples(3);
        set_power('0, '0);
        repeat (4) @(posedge clk);
        rd_chk("status fund a", OFS_EVENT_STATUS_0, 32'h0000_0040);
        rd_chk("sign fund a", OFS_PSIGN, 32'h0000_0005);
        wr(OFS_EVENT_STATUS_0, 32'hffff_ffff);
        rd_chk("status all clr", OFS_EVENT_STATUS_0, 32'h0000_0000);
        // Total path monitored again: B turns negative, C turns positive together
        wr(OFS_ACCUMULATION_MODE_CONTROL, 32'h0000_0000);
        set_power({24'sd1000, -24'sd1000, 24'sd0}, '0);
        wait_irq_low();
        samples(3);
        set_power('0, '0);
        repeat (4) @(posedge clk);
        rd_chk("status b c", OFS_EVENT_STATUS_0, 32'h0000_0180);
        rd_chk("sign b c", OFS_PSIGN, 32'h0000_0003);
        chk("sign pins bc", {29'h0, phase_power_negative}, 32'h3);
        final_report();
    end
endmodule
`default_nettype wire
